// ### dv/ppb_ext.sv
// external circuit on one pin group: line level from both sides
module ppb_ext #(
    parameter logic OPEN_DRAIN = 1'b1
) (
    // pins from the block and the far circuit's own level
    input  wire ppb_pkg::ppb_pins_t pins_i,
    input  wire logic [3:0]         drive_i,
    // resolved line level
    output logic [3:0]              level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // a driven line wins; open drain only pulls low, else pull-up and far side
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pins_i.oe[i] && (!OPEN_DRAIN || !pins_i.out[i])) begin
                level_o[i] = pins_i.out[i];
            end else begin
                level_o[i] = drive_i[i];
            end
        end
    end
endmodule

// ### dv/ppb_props.sv
// assertions on the ports of the parallel port block
module ppb_props #(
    parameter logic [2:0] FIXED_DIR = 3'b000
) (
    // clock, reset and register port
    input wire logic               sys_clk_i,
    input wire logic               rst_n_i,
    input wire ppb_pkg::ppb_req_t  req_i,
    input wire logic [3:0]         rdata_o,
    // standby and pins
    input wire logic               standby_i,
    input wire logic               wake_o,
    input wire logic [2:0]         fixed_in_i,
    input wire ppb_pkg::ppb_pins_t fixed_pins_o,
    input wire ppb_pkg::ppb_pins_t prog_pins_o,
    input wire ppb_pkg::ppb_pins_t ser_pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    // direction and programmable data registers: read value, write effect on pins
    AST_DIR_RD: assert property (req_i.rd && req_i.addr == 4'h8 |=> rdata_o == prog_pins_o.oe)
        else $error("direction read differs from driven enables");
    AST_DIR_WR: assert property (req_i.wr && req_i.addr == 4'h8 |=> ##1 prog_pins_o.oe == $past(req_i.wdata, 2))
        else $error("direction write not seen on enables");
    AST_PROG_WR: assert property (req_i.wr && req_i.addr == 4'h1 |=> ##1 prog_pins_o.out == $past(req_i.wdata, 2))
        else $error("programmable data write not seen on pins");
    // wake pulse follows a rising wake line in standby
    AST_WAKE: assert property (wake_o |-> $past(fixed_in_i[0], 2) && !$past(fixed_in_i[0], 3) && $past(standby_i))
        else $error("wake pulse without rising wake line in standby");
    // fixed and serial port drive, serial read bit0, read data hold
    AST_FIX_OE: assert property ($past(rst_n_i) |-> fixed_pins_o.oe == {1'b0, FIXED_DIR})
        else $error("fixed port enables differ from build option");
    AST_FIX_OUT: assert property (req_i.wr && req_i.addr == 4'h2 |=> ##1
        (fixed_pins_o.out[2:0] & FIXED_DIR) == ($past(req_i.wdata[2:0], 2) & FIXED_DIR))
        else $error("fixed port output lines not driven from data");
    AST_SER_OE: assert property ($past(rst_n_i) |-> ser_pins_o.oe[0])
        else $error("serial out line not driven");
    AST_SER_RD: assert property (req_i.rd && req_i.addr == 4'h7 |=> rdata_o[0] == ser_pins_o.out[0])
        else $error("serial read bit0 differs from driven level");
    AST_HOLD: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without a read");
endmodule

bind ppb_top ppb_props #(.FIXED_DIR(FIXED_DIR)) u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .rdata_o(rdata_o), .standby_i(standby_i), .wake_o(wake_o), .fixed_in_i(fixed_in_i),
    .fixed_pins_o(fixed_pins_o), .prog_pins_o(prog_pins_o), .ser_pins_o(ser_pins_o));

// ### dv/testbench.sv
// self-checking bench of the parallel port block
`define TB_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] FD = 3'b100;
    localparam logic [3:0] AL = 4'b0011;
    localparam logic [2:0] AH = 3'b100;
    logic               sys_clk_i = 1'b0;
    logic               rst_n_i   = 1'b0;
    logic               standby_i = 1'b0;
    ppb_pkg::ppb_req_t  req       = '0;
    logic [20:0]        ext       = '0;
    logic [1:0]         e_fx      = 2'b00;
    logic [31:0]        seed      = 32'h0001_6623;
    logic [31:0]        tmp;
    logic [3:0]         sh [16]   = '{default: 4'h0};
    logic               flag_d    = 1'b0;
    logic [3:0]         exp_q [$];
    logic [3:0]         exp_v, rdata, lv_prog, lv_fix, lv_alow, lv_ahi, lv_ser;
    logic               wake;
    ppb_pkg::ppb_pins_t p_prog, p_fix, p_alow, p_ahi, p_ser;
    ppb_pkg::ppb_pins_t a_alow, a_ahi, a_ser;
    logic [3:0]         rdata_a;
    logic               alt_cclk, alt_cref, alt_irq, alt_cnt, alt_sin;
    int                 n_errors = 0, n_compared = 0, n_wake = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // design and far-side circuit
    ppb_top #(.FIXED_DIR(FD), .ALOW_DIR(AL), .AHIGH_DIR(AH)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .req_i(req), .rdata_o(rdata), .standby_i(standby_i), .wake_o(wake), .prog_in_i(lv_prog),
        .prog_pins_o(p_prog), .fixed_in_i(lv_fix[2:0]), .fixed_pins_o(p_fix), .refclk_in_i(ext[6:5]),
        .conv_clock_o(), .conv_ref_o(), .alow_in_i(lv_alow), .alow_pins_o(p_alow), .ahigh_in_i(lv_ahi[2:0]),
        .ahigh_pins_o(p_ahi), .irqcnt_in_i(ext[15:14]), .ext_irq_o(), .counter_clock_o(),
        .ser_in_i(lv_ser[1:0]), .ser_pins_o(p_ser), .serial_data_out_i(ext[18]), .serial_io_out_i(ext[19]),
        .serial_io_oe_i(ext[20]), .serial_io_in_o());
    // second copy with every alternate function and the falling edge chosen
    ppb_top #(.FIXED_DIR(FD), .EDGE_RISE(1'b0), .REFCLK_ALT(1'b1), .ALOW_DIR(AL), .ALOW_ALT(1'b1), .AHIGH_DIR(AH),
        .AHIGH_ALT(1'b1), .IRQCNT_ALT(1'b1), .SER_IO_DIR(1'b1), .SER_ALT(1'b1)) u_alt (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata_a), .standby_i(standby_i), .wake_o(), .prog_in_i(lv_prog),
        .prog_pins_o(), .fixed_in_i(lv_fix[2:0]), .fixed_pins_o(), .refclk_in_i(ext[6:5]), .conv_clock_o(alt_cclk),
        .conv_ref_o(alt_cref), .alow_in_i(ext[10:7]), .alow_pins_o(a_alow), .ahigh_in_i(ext[13:11]),
        .ahigh_pins_o(a_ahi), .irqcnt_in_i(ext[15:14]), .ext_irq_o(alt_irq), .counter_clock_o(alt_cnt),
        .ser_in_i(ext[17:16]), .ser_pins_o(a_ser), .serial_data_out_i(ext[18]), .serial_io_out_i(ext[19]),
        .serial_io_oe_i(ext[20]), .serial_io_in_o(alt_sin));
    ppb_ext #(.OPEN_DRAIN(1'b1)) u_prog (.pins_i(p_prog), .drive_i(ext[3:0]), .level_o(lv_prog));
    ppb_ext #(.OPEN_DRAIN(1'b1)) u_alow (.pins_i(p_alow), .drive_i(ext[10:7]), .level_o(lv_alow));
    ppb_ext #(.OPEN_DRAIN(1'b1)) u_ahi (.pins_i(p_ahi), .drive_i({1'b0, ext[13:11]}), .level_o(lv_ahi));
    ppb_ext #(.OPEN_DRAIN(1'b0)) u_fix (.pins_i(p_fix), .drive_i({1'b0, ext[4], e_fx}), .level_o(lv_fix));
    ppb_ext #(.OPEN_DRAIN(1'b0)) u_ser (.pins_i(p_ser), .drive_i({2'b00, ext[17:16]}), .level_o(lv_ser));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, timeout, wake pulse count and read data check
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (wake === 1'b1) n_wake++;
        if (cyc > 3000) begin
            n_errors++;
            summarize();
        end
    end
    always @(posedge sys_clk_i) begin
        if (req.rd === 1'b1) begin
            #1;
            exp_v = exp_q.pop_front();
            `TB_CHK("rdata_o", exp_v, rdata)
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // stimulus helpers: random source, read model, one-cycle access
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [3:0] exp_rd(input logic [3:0] a);
        case (a)
            4'h1: return (sh[8] & sh[1]) | (~sh[8] & ext[3:0]);
            4'h2: return {flag_d, (FD & sh[2][2:0]) | (~FD & {ext[4], e_fx})};
            4'h3: return {2'b00, ext[6:5]};
            4'h4: return (AL & sh[4]) | (~AL & ext[10:7]);
            4'h5: return {1'b0, (AH & sh[5][2:0]) | (~AH & ext[13:11])};
            4'h6: return {2'b00, ext[15:14]};
            4'h7: return {2'b00, ext[17], sh[7][0]};
            4'h8: return sh[8];
            default: return 4'h0;
        endcase
    endfunction
    task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [3:0] d);
        @(negedge sys_clk_i);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        if (r) exp_q.push_back(exp_rd(a));
        if (w) sh[a] = d;
        if (w && a == 4'h2) flag_d = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge sys_clk_i);
            req = '0;
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        op(1'b0, 1'b1, 4'h8, 4'h0);
        for (int k = 0; k < 8; k++) begin
            tmp = rnd();
            ext = tmp[20:0];
            op(1'b1, 1'b0, 4'h1, tmp[24:21]);
            op(1'b1, 1'b1, 4'h8, tmp[28:25]);
            op(1'b0, 1'b1, 4'h8, 4'h0);
            for (int a = 2; a < 8; a++) op(1'b1, 1'b0, a[3:0], tmp[31:28] ^ a[3:0]);
            idle(3);
            for (int a = 0; a < 16; a++) op(1'b0, 1'b1, a[3:0], 4'h0);
            idle(1);
            `TB_CHK("prog_oe", sh[8], p_prog.oe)
            `TB_CHK("prog_out", sh[1], p_prog.out)
            `TB_CHK("ser_out0", sh[7][0], p_ser.out[0])
            `TB_CHK("alow_out", sh[4], p_alow.out)
            `TB_CHK("ahigh_out", {1'b0, sh[5][2:0]}, p_ahi.out)
            `TB_CHK("fixed_out", {1'b0, sh[2][2:0]}, p_fix.out)
            `TB_CHK("alt_conv", ext[6:5], {alt_cref, alt_cclk})
            `TB_CHK("alt_irqcnt", ext[15:14], {alt_cnt, alt_irq})
            `TB_CHK("alt_alow_oe", 4'h0, a_alow.oe)
            `TB_CHK("alt_ahigh_oe", 4'h4, a_ahi.oe)
            `TB_CHK("alt_ser", {ext[20], 1'b1, ext[19], ext[18]}, {a_ser.oe[1:0], a_ser.out[1:0]})
            `TB_CHK("alt_ser_in", ext[17], alt_sin)
        end
        e_fx[1] = 1'b1;
        idle(4);
        flag_d = 1'b1;
        op(1'b0, 1'b1, 4'h2, 4'h0);
        op(1'b1, 1'b0, 4'h2, 4'h0);
        op(1'b0, 1'b1, 4'h2, 4'h0);
        e_fx[1] = 1'b0;
        idle(4);
        op(1'b0, 1'b1, 4'h2, 4'h0);
        standby_i = 1'b1;
        e_fx = 2'b11;
        idle(4);
        `TB_CHK("alt_fall_flag", 1'b1, rdata_a[3])
        flag_d = 1'b1;
        standby_i = 1'b0;
        op(1'b0, 1'b1, 4'h2, 4'h0);
        e_fx[0] = 1'b0;
        idle(3);
        e_fx[0] = 1'b1;
        idle(4);
        `TB_CHK("wake_count", 32'd1, n_wake)
        summarize();
    end
endmodule

// ### hdl/ppb_defines.svh
// constants of the parallel port block: offsets, field positions, reset values
//
// How it works
// R1 - fixed port: option directions, write drives, read pins
// R2 - wake line rising edge ends standby
// R3 - edge-detect line edge sets fixed_port_data b3
// R4 - edge flag also sets during standby
// R5 - any fixed_port_data write clears edge flag; an edge in the same cycle sets it instead
// R6 - edge polarity chosen by build option
// R7 - ref/clock port reads two pins, or alternate
// R8 - analog low port: option directions, or converter
// R9 - software writes output data before relying
// R10 - analog high port: option directions, two converter
// R11 - irq/counter port reads two pins, or alternate
// R12 - serial port: line0 output, line1 option
// R13 - serial port read returns driven line0 level
// R14 - direction bit one output, zero input
// R15 - reset clears direction control register
// R16 - programmable port line n in bit n
// R17 - programmable port: outputs driven, inputs read
// R18 - data register access ignores direction setting
// R19 - software loads data before enabling outputs
// R20 - input writes ignored; reads sampled on clock
`ifndef PPB_DEFINES_SVH
`define PPB_DEFINES_SVH

// register offsets on the peripheral register port
`define PPB_OFS_PROG_DATA   4'h1
`define PPB_OFS_FIXED_DATA  4'h2
`define PPB_OFS_REFCLK_DATA 4'h3
`define PPB_OFS_ALOW_DATA   4'h4
`define PPB_OFS_AHIGH_DATA  4'h5
`define PPB_OFS_IRQCNT_DATA 4'h6
`define PPB_OFS_SER_DATA    4'h7
`define PPB_OFS_DIR_CTRL    4'h8

// field positions
`define PPB_FIXED_FLAG_BIT  3
`define PPB_WAKE_BIT        0
`define PPB_EDGE_BIT        1

// reset values
`define PPB_DIR_RST         4'h0
`define PPB_DATA_RST        4'h0
`define PPB_FIXED_RST       3'h0
`define PPB_AHIGH_RST       3'h0
`define PPB_SER_RST         2'h0

`endif

// ### hdl/ppb_pkg.sv
// types of the parallel port block
package ppb_pkg;

    // one peripheral register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [3:0] wdata;
    } ppb_req_t;

    // one pin group of up to four lines
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } ppb_pins_t;

endpackage

// ### hdl/ppb_top.sv
// parallel port block: seven ports behind the peripheral register port
`include "ppb_defines.svh"

module ppb_top #(
    parameter logic [2:0] FIXED_DIR  = 3'b000, // 1 = output, per fixed port line
    parameter logic       EDGE_RISE  = 1'b1,   // edge detector polarity
    parameter logic       REFCLK_ALT = 1'b0,   // ref/clock port as converter inputs
    parameter logic [3:0] ALOW_DIR   = 4'h0,
    parameter logic       ALOW_ALT   = 1'b0,   // analog low port as converter inputs
    parameter logic [2:0] AHIGH_DIR  = 3'b000,
    parameter logic       AHIGH_ALT  = 1'b0,   // lines 0,1 as converter inputs
    parameter logic       IRQCNT_ALT = 1'b0,   // irq/counter port as alternate inputs
    parameter logic       SER_IO_DIR = 1'b0,   // serial io line 1 = output
    parameter logic       SER_ALT    = 1'b0    // serial port used by the serial unit
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    // peripheral register port
    input  wire ppb_pkg::ppb_req_t req_i,
    output logic [3:0]            rdata_o,
    // standby control
    input  wire logic             standby_i,
    output logic                  wake_o,
    // programmable port, open drain
    input  wire logic [3:0]       prog_in_i,
    output ppb_pkg::ppb_pins_t    prog_pins_o,
    // fixed port
    input  wire logic [2:0]       fixed_in_i,
    output ppb_pkg::ppb_pins_t    fixed_pins_o,
    // ref/clock input port and its alternate outputs
    input  wire logic [1:0]       refclk_in_i,
    output logic                  conv_clock_o,
    output logic                  conv_ref_o,
    // analog shared ports
    input  wire logic [3:0]       alow_in_i,
    output ppb_pkg::ppb_pins_t    alow_pins_o,
    input  wire logic [2:0]       ahigh_in_i,
    output ppb_pkg::ppb_pins_t    ahigh_pins_o,
    // irq/counter input port and its alternate outputs
    input  wire logic [1:0]       irqcnt_in_i,
    output logic                  ext_irq_o,
    output logic                  counter_clock_o,
    // serial shared port and serial unit side
    input  wire logic [1:0]       ser_in_i,
    output ppb_pkg::ppb_pins_t    ser_pins_o,
    input  wire logic             serial_data_out_i,
    input  wire logic             serial_io_out_i,
    input  wire logic             serial_io_oe_i,
    output logic                  serial_io_in_o
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [3:0] dir_r;
    logic [3:0] prog_data_r;
    logic [2:0] fixed_data_r;
    logic       flag_r;
    logic [3:0] alow_data_r;
    logic [2:0] ahigh_data_r;
    logic [1:0] ser_data_r;
    logic [3:0] prog_s_r;
    logic [2:0] fixed_s_r;
    logic [2:0] fixed_p_r;
    logic [1:0] refclk_s_r;
    logic [3:0] alow_s_r;
    logic [2:0] ahigh_s_r;
    logic [1:0] irqcnt_s_r;
    logic [1:0] ser_s_r;
    logic       wr_fixed;
    logic       edge_hit;
    logic       wake_hit;
    logic       ser0_lvl;
    logic [3:0] rd_nxt;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling

    // every pin input is taken once on the clock before any use
    // samples carry no reset: pins must idle before reset ends,
    // else a stale sample can look like an edge in the first cycles
    always_ff @(posedge sys_clk_i) begin
        prog_s_r   <= prog_in_i;   // see R20
        fixed_s_r  <= fixed_in_i;
        fixed_p_r  <= fixed_s_r;
        refclk_s_r <= refclk_in_i;
        alow_s_r   <= alow_in_i;
        ahigh_s_r  <= ahigh_in_i;
        irqcnt_s_r <= irqcnt_in_i;
        ser_s_r    <= ser_in_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes

    // any write to the fixed port register, used as the flag clear
    assign wr_fixed = req_i.wr && (req_i.addr == `PPB_OFS_FIXED_DATA);

    // direction control, cleared on reset
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dir_r <= `PPB_DIR_RST;   // see R15
        end else if (req_i.wr && req_i.addr == `PPB_OFS_DIR_CTRL) begin
            dir_r <= req_i.wdata;    // see R14
        end
    end

    // programmable port data, accepted whatever the direction
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            prog_data_r <= `PPB_DATA_RST;
        end else if (req_i.wr && req_i.addr == `PPB_OFS_PROG_DATA) begin
            prog_data_r <= req_i.wdata;          // see R18
        end
    end

    // fixed port data, three lines; b3 of the register is the flag
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fixed_data_r <= `PPB_FIXED_RST;
        end else if (wr_fixed) begin
            fixed_data_r <= req_i.wdata[2:0];    // see R1
        end
    end

    // analog low port data, four lines
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            alow_data_r <= `PPB_DATA_RST;
        end else if (req_i.wr && req_i.addr == `PPB_OFS_ALOW_DATA) begin
            alow_data_r <= req_i.wdata;          // see R8
        end
    end

    // analog high port data, three lines
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ahigh_data_r <= `PPB_AHIGH_RST;
        end else if (req_i.wr && req_i.addr == `PPB_OFS_AHIGH_DATA) begin
            ahigh_data_r <= req_i.wdata[2:0];    // see R10
        end
    end

    // serial port data, two lines
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ser_data_r <= `PPB_SER_RST;
        end else if (req_i.wr && req_i.addr == `PPB_OFS_SER_DATA) begin
            ser_data_r <= req_i.wdata[1:0];      // see R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge detector and wake

    // selected edge on the edge-detect line while it is an input
    // an output edge line never sets the flag, whatever its pin does
    assign edge_hit = !FIXED_DIR[`PPB_EDGE_BIT] &&
                      (EDGE_RISE ? (fixed_s_r[`PPB_EDGE_BIT] && !fixed_p_r[`PPB_EDGE_BIT])
                                 : (!fixed_s_r[`PPB_EDGE_BIT] && fixed_p_r[`PPB_EDGE_BIT])); // see R6
    assign wake_hit = !FIXED_DIR[`PPB_WAKE_BIT] && standby_i &&
                      fixed_s_r[`PPB_WAKE_BIT] && !fixed_p_r[`PPB_WAKE_BIT];

    // sticky flag: set in or out of standby, set wins over the write clear
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            flag_r <= 1'b0;
        end else if (edge_hit) begin
            flag_r <= 1'b1;          // see R3, see R4
        end else if (wr_fixed) begin
            flag_r <= 1'b0;          // see R5
        end
    end

    // one-cycle wake pulse to the cpu sequencer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= wake_hit;      // see R2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux

    assign ser0_lvl = SER_ALT ? serial_data_out_i : ser_data_r[0];

    // output lines read back their data, input lines their pins, converter and irq/counter alternate lines zero
    // the mux sees registers before this edge's write, so a read
    // and a write in one cycle return the old value
    always_comb begin
        rd_nxt = 4'h0;
        case (req_i.addr)
            `PPB_OFS_PROG_DATA:   rd_nxt = (dir_r & prog_data_r) | (~dir_r & prog_s_r); // see R16, see R17
            `PPB_OFS_FIXED_DATA:  rd_nxt = {flag_r, (FIXED_DIR & fixed_data_r) | (~FIXED_DIR & fixed_s_r)}; // see R1
            `PPB_OFS_REFCLK_DATA: rd_nxt = REFCLK_ALT ? 4'h0 : {2'h0, refclk_s_r};   // see R7
            `PPB_OFS_ALOW_DATA:   rd_nxt = ALOW_ALT ? 4'h0 : ((ALOW_DIR & alow_data_r) | (~ALOW_DIR & alow_s_r));
            `PPB_OFS_AHIGH_DATA:  rd_nxt = {1'b0, (AHIGH_DIR & ahigh_data_r) | (~AHIGH_DIR & ahigh_s_r)} &
                                           (AHIGH_ALT ? 4'h4 : 4'hf);                 // see R10
            `PPB_OFS_IRQCNT_DATA: rd_nxt = IRQCNT_ALT ? 4'h0 : {2'h0, irqcnt_s_r};   // see R11
            `PPB_OFS_SER_DATA:    rd_nxt = {2'h0, (SER_IO_DIR && !SER_ALT) ? ser_data_r[1] : ser_s_r[1],
                                            ser0_lvl};                                // see R13
            `PPB_OFS_DIR_CTRL:    rd_nxt = dir_r;
            default:              rd_nxt = 4'h0;
        endcase
    end

    // read data registered, held until the next read
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 4'h0;
        end else if (req_i.rd) begin
            rdata_o <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    // programmable port: level from data, enable from direction
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            prog_pins_o <= '0;
        end else begin
            prog_pins_o.out <= prog_data_r;
            prog_pins_o.oe  <= dir_r;                                  // see R17
        end
    end

    // fixed port: enables fixed by the build option
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fixed_pins_o <= '0;
        end else begin
            fixed_pins_o.out <= {1'b0, fixed_data_r};
            fixed_pins_o.oe  <= {1'b0, FIXED_DIR};                     // see R1
        end
    end

    // analog low port: converter use releases all four lines
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            alow_pins_o <= '0;
        end else begin
            alow_pins_o.out <= alow_data_r;
            alow_pins_o.oe  <= ALOW_ALT ? 4'h0 : ALOW_DIR;             // see R8
        end
    end

    // analog high port: converter use releases lines 0 and 1
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ahigh_pins_o <= '0;
        end else begin
            ahigh_pins_o.out <= {1'b0, ahigh_data_r};
            ahigh_pins_o.oe  <= {1'b0, AHIGH_DIR & (AHIGH_ALT ? 3'b100 : 3'b111)}; // see R10
        end
    end

    // serial port: line 0 always driven, line 1 by option or serial unit
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ser_pins_o <= '0;
        end else begin
            ser_pins_o.out <= {2'h0, SER_ALT ? serial_io_out_i : ser_data_r[1], ser0_lvl};
            ser_pins_o.oe  <= {2'h0, SER_ALT ? serial_io_oe_i : SER_IO_DIR, 1'b1}; // see R12
        end
    end

    // converter clock and reference handed over from the ref/clock port
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            conv_clock_o <= 1'b0;
            conv_ref_o   <= 1'b0;
        end else begin
            conv_clock_o <= REFCLK_ALT & refclk_s_r[0];   // see R7
            conv_ref_o   <= REFCLK_ALT & refclk_s_r[1];
        end
    end

    // interrupt and counter clock handed over from the irq/counter port
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ext_irq_o       <= 1'b0;
            counter_clock_o <= 1'b0;
        end else begin
            ext_irq_o       <= IRQCNT_ALT & irqcnt_s_r[0];   // see R11
            counter_clock_o <= IRQCNT_ALT & irqcnt_s_r[1];
        end
    end

    // serial data in handed to the serial unit
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            serial_io_in_o <= 1'b0;
        end else begin
            serial_io_in_o <= SER_ALT & ser_s_r[1];
        end
    end

endmodule
